// *** rtl/fctce_engine.sv ***
// Purpose: four-channel timer counting core
// Assumes: configuration ports are steady on mclk; pins are asynchronous
// Notes: output waveform modes, preload and pin filters are not present
module fctce_engine
  import fctce_pkg::*;
#(
  parameter int NCH = CHANNELS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Module input pins
  input wire logic [PINS-1:0] timerPin,
  // Shared control
  input wire logic [NCH-1:0] channelEnable,
  input wire logic debugMode,
  // Per-channel configuration, packed by channel
  input wire logic [NCH*4-1:0] primarySel,
  input wire logic [NCH*2-1:0] secondarySel,
  input wire logic [NCH-1:0] input_polarity_invert,
  input wire logic [NCH*3-1:0] countMode,
  input wire logic [NCH*3-1:0] captureMode,
  input wire logic [NCH-1:0] lengthCompare,
  input wire logic [NCH-1:0] countDown,
  input wire logic [NCH-1:0] countOnce,
  input wire logic [NCH*2-1:0] debugAction,
  input wire logic [NCH*CNT_W-1:0] loadValue,
  input wire logic [NCH*CNT_W-1:0] compare1,
  input wire logic [NCH*CNT_W-1:0] compare2,
  // Status flags and masked clear
  input wire logic [NCH*FLAG_W-1:0] flagClear,
  input wire logic [NCH*FLAG_W-1:0] flagIntEnable,
  output logic [NCH*FLAG_W-1:0] statusFlags,
  output logic [NCH-1:0] flagIrq,
  // Counter view
  output logic [NCH*CNT_W-1:0] countValue,
  output logic [NCH*CNT_W-1:0] captureValue,
  output logic [NCH-1:0] channel_output_signal
);
  logic [PINS-1:0] pinLevel;
  logic [PINS-1:0] pinRise;
  logic [PINS-1:0] pinFall;
  logic [6:0] prescaler;
  logic [6:0] prescPrev;
  logic [7:0] prescRise;
  logic [NCH-1:0] outPrev;
  logic [NCH-1:0] outState;
  logic [NCH-1:0] compareEvent;
  logic [NCH*CNT_W-1:0] counter;
  logic [NCH*CNT_W-1:0] capture;
  logic [NCH*FLAG_W-1:0] flags;
  fctce_run_type runState [NCH];

  // =========================================
  // Pin synchroniser
  // =========================================
  // four shared input pins
  fctce_pin_sync #(
    .WIDTH(PINS)
  ) u_pin_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pinAsync(timerPin),
    .pinLevel(pinLevel),
    .pinRise(pinRise),
    .pinFall(pinFall)
  );

  // =========================================
  // Shared prescaler
  // =========================================
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prescaler <= PRESC_RESET;
      prescPrev <= PRESC_RESET;
    end
    else
    begin
      prescaler <= prescaler + 7'h01;
      prescPrev <= prescaler;
    end
  end

  // divided clock ticks; divide by 1 ticks every cycle
  always_comb
  begin
    prescRise[0] = 1'b1;
    for (int b = 0; b < 7; b++)
      prescRise[b+1] = prescaler[b] & ~prescPrev[b];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      outPrev <= '0;
    else
      outPrev <= outState;
  end

  // Output held at zero under a forcing debug action
  assign channel_output_signal = outState;
  assign countValue = counter;
  assign captureValue = capture;
  assign statusFlags = flags;

  // =========================================
  // Per-channel counting
  // =========================================
  for (genvar ch = 0; ch < NCH; ch++)
  begin : g_chan
    fctce_mode_type mode;
    fctce_cap_type capSel;
    fctce_dbg_type dbgSel;
    logic [3:0] pSel;
    logic [1:0] sSel;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp1;
    logic [CNT_W-1:0] cmp2;
    logic [CNT_W-1:0] load;
    logic fromPin;
    logic priRaw;
    logic priLevel;
    logic priActEdge;
    logic priAnyEdge;
    logic secLevel;
    logic secRiseRaw;
    logic secFallRaw;
    logic secActEdge;
    logic secActive;
    logic capHit;
    logic doCount;
    logic goDown;
    logic halted;
    logic atMatch;
    logic atRoll;
    logic priNow;
    logic cascadeIn;
    logic [FLAG_W-1:0] setFlag;

    assign mode = fctce_mode_type'(countMode[ch*3 +: 3]);
    assign capSel = fctce_cap_type'(captureMode[ch*3 +: 3]);
    assign dbgSel = fctce_dbg_type'(debugAction[ch*2 +: 2]);
    assign pSel = primarySel[ch*4 +: 4];
    assign sSel = secondarySel[ch*2 +: 2];
    assign cnt = counter[ch*CNT_W +: CNT_W];
    assign cmp1 = compare1[ch*CNT_W +: CNT_W];
    assign cmp2 = compare2[ch*CNT_W +: CNT_W];
    assign load = loadValue[ch*CNT_W +: CNT_W];
    assign fromPin = (pSel < PRI_CHAN_BASE);
    // cascade takes the compare event, not the output signal
    // Only lower channels may feed it, so no chain of channels can loop
    assign cascadeIn = (int'(pSel[1:0]) < ch) ? compareEvent[pSel[1:0]] : 1'b0;

    always_comb
    begin
      priRaw = 1'b0;
      priNow = 1'b0;
      if (fromPin)
      begin
        priRaw = pinRise[pSel[1:0]] | pinFall[pSel[1:0]];
        priNow = pinLevel[pSel[1:0]];
      end
      else if (pSel < PRI_CLK_BASE)
      begin
        priRaw = outState[pSel[1:0]] ^ outPrev[pSel[1:0]];
        priNow = outState[pSel[1:0]];
      end
      else
      begin
        priRaw = prescRise[pSel[2:0]];
        priNow = 1'b1;
      end
    end

    // polarity invert for pin sources; rising for others
    always_comb
    begin
      priLevel = priNow;
      priActEdge = priRaw & priNow;
      if (fromPin)
      begin
        priLevel = priNow ^ input_polarity_invert[ch];
        priActEdge = input_polarity_invert[ch] ? pinFall[pSel[1:0]] : pinRise[pSel[1:0]];
      end
      else if (pSel >= PRI_CLK_BASE)
        priActEdge = priRaw;
    end
    assign priAnyEdge = priRaw;

    assign secLevel = pinLevel[sSel];
    assign secRiseRaw = pinRise[sSel];
    assign secFallRaw = pinFall[sSel];
    assign secActive = secLevel ^ input_polarity_invert[ch];
    assign secActEdge = input_polarity_invert[ch] ? secFallRaw : secRiseRaw;

    always_comb
    begin
      unique case (capSel)
        CAP_RISE, CAP_RISE_RL: capHit = secRiseRaw;
        CAP_FALL, CAP_FALL_RL: capHit = secFallRaw;
        CAP_BOTH, CAP_BOTH_RL: capHit = secRiseRaw | secFallRaw;
        default: capHit = 1'b0;
      endcase
    end

    assign halted = debugMode & ((dbgSel == DBG_HALT) | (dbgSel == DBG_HALT_FORCE0));

    // count event and direction per mode
    always_comb
    begin
      doCount = 1'b0;
      goDown = countDown[ch];
      unique case (mode)
        CM_NOOP: doCount = 1'b0;
        CM_ACTIVE: doCount = priActEdge;
        CM_BOTH: doCount = priAnyEdge;
        CM_GATED: doCount = priActEdge & secActive;
        CM_QUAD:
        begin
          // Exactly one input changing is one quadrature step; both at once count nothing
          doCount = priAnyEdge ^ (secRiseRaw | secFallRaw);
          goDown = priAnyEdge ? (priLevel == secLevel) : (priLevel != secLevel);
        end
        CM_DIR:
        begin
          doCount = priActEdge;
          goDown = secActive;
        end
        CM_TRIG: doCount = priActEdge & (runState[ch] == RUN_COUNT);
        CM_CASCADE: doCount = cascadeIn & (ch != 0);
      endcase
    end

    assign atMatch = goDown ? (cnt == cmp2) : (cnt == cmp1);
    assign atRoll = goDown ? (cnt == CNT_RESET) : (cnt == ROLL_VALUE);

    always_comb
    begin
      setFlag = '0;
      if (channelEnable[ch] & ~halted & doCount)
      begin
        setFlag[FLAG_CMP] = lengthCompare[ch] & atMatch;
        setFlag[FLAG_CMP1] = ~goDown & (cnt == cmp1);
        setFlag[FLAG_CMP2] = goDown & (cnt == cmp2);
        setFlag[FLAG_OVF] = atRoll;
      end
      setFlag[FLAG_EDGE] = capHit;
    end
    assign compareEvent[ch] = setFlag[FLAG_CMP];

    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        runState[ch] <= RUN_IDLE;
      else if (!channelEnable[ch] || mode == CM_NOOP)
        runState[ch] <= RUN_IDLE;
      else
      begin
        unique case (runState[ch])
          RUN_IDLE:
            runState[ch] <= (mode == CM_TRIG) ? RUN_ARMED : RUN_COUNT;
          RUN_ARMED:
            // A trigger, or disable or CM_NOOP via idle, restarts counting; else a finished one-shot stays stopped, but cascade mode counts in any state
            if (mode == CM_TRIG && secActEdge)
              runState[ch] <= RUN_COUNT;
          RUN_COUNT:
            // second trigger stops unless reinit capture variant is set
            if (mode == CM_TRIG && secActEdge && !capSel[2])
              runState[ch] <= RUN_ARMED;
            // one-shot ends after the terminal count
            else if (countOnce[ch] && (setFlag[FLAG_CMP] | setFlag[FLAG_OVF]))
              runState[ch] <= RUN_ARMED;
          default:
            runState[ch] <= RUN_IDLE;
        endcase
      end
    end

    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        counter[ch*CNT_W +: CNT_W] <= CNT_RESET;
      // reload on capturing edge in reload variants
      else if (capHit && capSel[2])
        counter[ch*CNT_W +: CNT_W] <= load;
      // second trigger reinitialises in reinit variant
      else if (mode == CM_TRIG && runState[ch] == RUN_COUNT && secActEdge && capSel[2])
        counter[ch*CNT_W +: CNT_W] <= load;
      else if (channelEnable[ch] && !halted && doCount
               && (runState[ch] == RUN_COUNT || mode == CM_CASCADE))
      begin
        // compare length reinitialises at the match
        if (lengthCompare[ch] && atMatch)
          counter[ch*CNT_W +: CNT_W] <= load;
        else if (goDown)
          counter[ch*CNT_W +: CNT_W] <= cnt - 16'h0001;
        else
          counter[ch*CNT_W +: CNT_W] <= cnt + 16'h0001;
      end
    end

    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        capture[ch*CNT_W +: CNT_W] <= CNT_RESET;
      else if (capHit)
        capture[ch*CNT_W +: CNT_W] <= cnt;
    end

    // sticky flags; set wins over masked clear
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        flags[ch*FLAG_W +: FLAG_W] <= '0;
      else
        flags[ch*FLAG_W +: FLAG_W] <= (flags[ch*FLAG_W +: FLAG_W] & ~flagClear[ch*FLAG_W +: FLAG_W]) | setFlag;
    end

    assign flagIrq[ch] = |(flags[ch*FLAG_W +: FLAG_W] & flagIntEnable[ch*FLAG_W +: FLAG_W]);

    // output toggles on compare, forced low by debug action
    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        outState[ch] <= 1'b0;
      else if (debugMode && dbgSel[1])
        outState[ch] <= 1'b0;
      else if (setFlag[FLAG_CMP])
        outState[ch] <= ~outState[ch];
    end
  end
endmodule : fctce_engine

// *** rtl/fctce_pkg.sv ***
// Purpose: constants and types for the four-channel timer count engine
// Assumes: one clock (mclk, 40 MHz), synchronous active-high reset
// Notes: configuration and status are plain ports, no register bus
package fctce_pkg;
  localparam int CHANNELS = 4;
  localparam int PINS = 4;
  localparam int CNT_W = 16;
  localparam logic [15:0] ROLL_VALUE = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  // Flag positions in a channel status word
  localparam int FLAG_CMP = 0;
  localparam int FLAG_CMP1 = 1;
  localparam int FLAG_CMP2 = 2;
  localparam int FLAG_OVF = 3;
  localparam int FLAG_EDGE = 4;
  localparam int FLAG_W = 5;
  // Primary source codes: 0..3 pins, 4..7 channel outputs, 8..15 clock/2^n
  localparam logic [3:0] PRI_CHAN_BASE = 4'h4;
  localparam logic [3:0] PRI_CLK_BASE = 4'h8;
  typedef enum logic [2:0] {
    CM_NOOP = 3'h0, CM_ACTIVE = 3'h1, CM_BOTH = 3'h2, CM_GATED = 3'h3,
    CM_QUAD = 3'h4, CM_DIR = 3'h5, CM_TRIG = 3'h6, CM_CASCADE = 3'h7
  } fctce_mode_type;
  // Capture codes: 0 off, 1 rise, 2 fall, 3 both, 5..7 same with reload
  typedef enum logic [2:0] {
    CAP_OFF = 3'h0, CAP_RISE = 3'h1, CAP_FALL = 3'h2, CAP_BOTH = 3'h3,
    CAP_RISE_RL = 3'h5, CAP_FALL_RL = 3'h6, CAP_BOTH_RL = 3'h7
  } fctce_cap_type;
  typedef enum logic [1:0] {
    DBG_RUN = 2'h0, DBG_HALT = 2'h1, DBG_FORCE0 = 2'h2, DBG_HALT_FORCE0 = 2'h3
  } fctce_dbg_type;
  typedef enum logic [2:0] {
    RUN_IDLE = 3'b001, RUN_ARMED = 3'b010, RUN_COUNT = 3'b100
  } fctce_run_type;
endpackage : fctce_pkg

// *** rtl/fctce_pin_sync.sv ***
// Purpose: bring the input pins into the mclk domain and mark their edges
// Assumes: pins are asynchronous to mclk
// Notes: edge pulses lag the pin by two mclk edges
module fctce_pin_sync
  import fctce_pkg::*;
#(
  parameter int WIDTH = PINS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Pins
  input wire logic [WIDTH-1:0] pinAsync,
  // Synchronised view
  output logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] pinRise,
  output logic [WIDTH-1:0] pinFall
);
  logic [WIDTH-1:0] syncFirst;
  logic [WIDTH-1:0] syncSecond;

  // =========================================
  // Two-stage synchroniser
  // =========================================
  // pin synchronisation
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      syncFirst <= '0;
      syncSecond <= '0;
    end
    else
    begin
      syncFirst <= pinAsync;
      syncSecond <= syncFirst;
    end
  end

  // =========================================
  // Edge detection on the second stage only
  // =========================================
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pinLevel <= '0;
    else
      pinLevel <= syncSecond;
  end

  assign pinRise = syncSecond & ~pinLevel;
  assign pinFall = ~syncSecond & pinLevel;
endmodule : fctce_pin_sync

// *** testbench/fctce_engine_properties.sv ***
// Purpose: port-level timing checks of the count engine
// Assumes: one mclk domain, synchronous active-high reset
// Notes: detailed checks watch channels 0 and 1 only
module fctce_engine_properties
  import fctce_pkg::*;
#(
  parameter int NCH = CHANNELS
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Inputs watched
  input wire logic [NCH-1:0] channelEnable,
  input wire logic debugMode,
  input wire logic [NCH*4-1:0] primarySel,
  input wire logic [NCH*3-1:0] countMode,
  input wire logic [NCH-1:0] countDown,
  input wire logic [NCH*2-1:0] debugAction,
  input wire logic [NCH*FLAG_W-1:0] flagClear,
  input wire logic [NCH*FLAG_W-1:0] flagIntEnable,
  // Outputs watched
  input wire logic [NCH*FLAG_W-1:0] statusFlags,
  input wire logic [NCH-1:0] flagIrq,
  input wire logic [NCH*CNT_W-1:0] countValue,
  input wire logic [NCH*CNT_W-1:0] captureValue,
  input wire logic [NCH-1:0] channel_output_signal
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Assertions
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> countValue == '0 && statusFlags == '0
    && captureValue == '0 && channel_output_signal == '0) else $error("state not cleared by reset");
  genvar g;
  for (g = 0; g < NCH; g++)
  begin : g_irq
    a_irq_of_flags: assert property (flagIrq[g] == |(statusFlags[g*FLAG_W +: FLAG_W]
      & flagIntEnable[g*FLAG_W +: FLAG_W])) else $error("irq does not match flags");
  end
  a_flags_sticky: assert property (1'b1 |=> ($past(statusFlags) & ~$past(flagClear) & ~statusFlags) == '0)
    else $error("flag dropped without clear");
  a_disabled_holds: assert property (!channelEnable[0] && !$past(channelEnable[0]) |=> $stable(countValue[15:0]))
    else $error("disabled channel counted");
  a_debug_halts: assert property (debugMode && $past(debugMode) && debugAction[1:0] == DBG_HALT
    && $past(debugAction[1:0]) == DBG_HALT |=> $stable(countValue[15:0])) else $error("halted channel counted");
  a_enable_walk: assert property ($rose(channelEnable[0]) && countMode[2:0] == CM_ACTIVE && primarySel[3:0] == 4'h8
    && !countDown[0] && countValue[15:0] == 16'h0000 |-> ##[1:3] countValue[15:0] == 16'h0001)
    else $error("enabled channel did not start");
  a_wrap_sets_ovf: assert property (!$past(sys_rst) && $past(countDown[1]) && $past(countValue[31:16]) == 16'h0000
    && countValue[31:16] == 16'hFFFF |-> statusFlags[FLAG_W+FLAG_OVF]) else $error("wrap without overflow flag");
  a_div2_spacing: assert property (primarySel[3:0] == 4'h9 && $past(primarySel[3:0], 2) == 4'h9
    && countMode[2:0] == CM_ACTIVE && $changed(countValue[15:0]) |=> $stable(countValue[15:0]))
    else $error("divide by two counted twice in a row");
  a_debug_force0: assert property (debugMode && debugAction[1] |-> ##[0:2] !channel_output_signal[0])
    else $error("output not forced low in debug");
  c_enable: cover property ($rose(channelEnable[0]));
  c_overflow: cover property ($rose(statusFlags[FLAG_W+FLAG_OVF]));
  c_edge: cover property ($rose(statusFlags[FLAG_EDGE]));
endmodule : fctce_engine_properties

// *** testbench/test_four_channel_timer_count_engine.sv ***
// Purpose: self-checking bench of the count engine
// Assumes: 40 MHz mclk, reset held 10 cycles
// Notes: quadrature mode is left to later work
module test_four_channel_timer_count_engine
  import fctce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int kind; int ch; logic [15:0] exp;} fctce_note_type;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] timerPin = '0;
  logic [3:0] channelEnable = '0;
  logic debugMode = 1'b0;
  logic [15:0] primarySel = '0;
  logic [7:0] secondarySel = '0;
  logic [3:0] input_polarity_invert = '0;
  logic [11:0] countMode = '0;
  logic [11:0] captureMode = '0;
  logic [3:0] lengthCompare = '0;
  logic [3:0] countDown = '0;
  logic [3:0] countOnce = '0;
  logic [7:0] debugAction = '0;
  logic [63:0] loadValue = 64'h1000100010001000;
  logic [63:0] compare1 = 64'h8000800080008000;
  logic [63:0] compare2 = 64'h8000800080008000;
  logic [19:0] flagClear = '0;
  logic [19:0] flagIntEnable = '0;
  logic [19:0] statusFlags;
  logic [3:0] flagIrq;
  logic [63:0] countValue;
  logic [63:0] captureValue;
  logic [3:0] channel_output_signal;
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'hC81E;
  fctce_note_type notes[$];
  fctce_note_type cur;
  always #12.5 mclk = ~mclk;
  fctce_engine #(.NCH(4)) uut (.mclk(mclk), .sys_rst(sys_rst), .timerPin(timerPin), .channelEnable(channelEnable),
    .debugMode(debugMode), .primarySel(primarySel), .secondarySel(secondarySel),
    .input_polarity_invert(input_polarity_invert), .countMode(countMode), .captureMode(captureMode),
    .lengthCompare(lengthCompare), .countDown(countDown), .countOnce(countOnce), .debugAction(debugAction),
    .loadValue(loadValue), .compare1(compare1), .compare2(compare2), .flagClear(flagClear),
    .flagIntEnable(flagIntEnable), .statusFlags(statusFlags), .flagIrq(flagIrq), .countValue(countValue),
    .captureValue(captureValue), .channel_output_signal(channel_output_signal));
  // ==========
  // Compare and report
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val
  task automatic cmp_flags(input logic [4:0] exp, input logic [4:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] flags expected %h seen %h", exp, got);
    end
  endtask : cmp_flags
  task automatic final_report();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Oldest note is compared on the falling edge, away from input updates
  always @(negedge mclk)
  begin
    if (notes.size() > 0)
    begin
      cur = notes.pop_front();
      case (cur.kind)
        0: cmp_val("count", cur.exp, countValue[cur.ch*16 +: 16]);
        1: cmp_val("capture", cur.exp, captureValue[cur.ch*16 +: 16]);
        2: cmp_flags(cur.exp[4:0], statusFlags[cur.ch*5 +: 5]);
        default: cmp_val("output", cur.exp, {15'h0000, channel_output_signal[cur.ch]});
      endcase
    end
  end
  // ==========
  // Stimulus helpers
  task automatic note(input int kind, input int ch, input logic [15:0] exp);
    notes.push_back('{kind, ch, exp});
  endtask : note
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic cfg(input int ch, input logic [3:0] sel, input logic [1:0] sec, input logic [2:0] mode,
    input logic [2:0] cap, input logic down, input logic inv);
    @(posedge mclk);
    primarySel[ch*4 +: 4] <= sel;
    secondarySel[ch*2 +: 2] <= sec;
    countMode[ch*3 +: 3] <= mode;
    captureMode[ch*3 +: 3] <= cap;
    countDown[ch] <= down;
    input_polarity_invert[ch] <= inv;
    cyc(6);
  endtask : cfg
  task automatic snap(input int ch, output logic [15:0] v);
    @(negedge mclk);
    v = countValue[ch*16 +: 16];
  endtask : snap
  task automatic delta_check(input int ch, input int win, input logic [15:0] d);
    logic [15:0] b;
    snap(ch, b);
    cyc(win);
    note(0, ch, b + d);
  endtask : delta_check
  task automatic pulse(input int pin, input logic inv, input int n);
    repeat (n)
    begin
      @(posedge mclk);
      timerPin[pin] <= ~inv;
      cyc(5);
      timerPin[pin] <= inv;
      cyc(5);
    end
    cyc(6);
  endtask : pulse
  // ==========
  // Main sequence
  initial
  begin
    logic [15:0] b;
    int n;
    logic inv;
    cyc(10);
    sys_rst <= 1'b0;
    flagIntEnable <= 20'($random(seed));
    for (int c = 0; c < 4; c++)
    begin
      @(posedge mclk);
      note(0, c, 16'h0000);
      @(posedge mclk);
      note(2, c, 16'h0000);
    end
    cfg(0, 4'h8, 2'h3, CM_ACTIVE, CAP_OFF, 1'b0, 1'b0);
    channelEnable[0] <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      cfg(0, 4'(8 + k), 2'h3, CM_ACTIVE, CAP_OFF, 1'b0, 1'b0);
      delta_check(0, 256, 16'(256 >> k));
    end
    cfg(1, 4'h4, 2'h3, CM_CASCADE, CAP_OFF, 1'b0, 1'b0);
    channelEnable[1] <= 1'b1;
    cfg(0, 4'h8, 2'h3, CM_ACTIVE, CAP_OFF, 1'b0, 1'b0);
    // One-shot compare run leaves output high for the force check
    snap(0, b);
    @(posedge mclk);
    compare1[15:0] <= b + 16'h0010;
    lengthCompare[0] <= 1'b1;
    countOnce[0] <= 1'b1;
    cyc(40);
    note(0, 0, 16'h1000);
    @(posedge mclk);
    note(2, 0, 16'h0003);
    @(posedge mclk);
    note(3, 0, 16'h0001);
    @(posedge mclk);
    note(0, 1, 16'h0001);
    channelEnable[1:0] <= 2'b00;
    lengthCompare[0] <= 1'b0;
    countOnce[0] <= 1'b0;
    flagClear[4:0] <= 5'h03;
    @(posedge mclk);
    channelEnable[0] <= 1'b1;
    flagClear <= '0;
    for (int a = 0; a < 4; a++)
    begin
      @(posedge mclk);
      debugAction[1:0] <= 2'(a);
      debugMode <= 1'b1;
      cyc(4);
      delta_check(0, 32, a[0] ? 16'h0000 : 16'h0020);
      if (a[1])
        note(3, 0, 16'h0000);
      cyc(2);
    end
    debugMode <= 1'b0;
    channelEnable[0] <= 1'b0;
    cyc(4);
    delta_check(0, 32, 16'h0000);
    // Down count from one wraps after two counts
    cfg(1, 4'h8, 2'h3, CM_ACTIVE, CAP_OFF, 1'b1, 1'b0);
    channelEnable[1] <= 1'b1;
    for (n = 0; n < 20 && statusFlags[FLAG_W+FLAG_OVF] !== 1'b1; n++)
      @(negedge mclk);
    if (n == 20)
    begin
      error_cnt++;
      final_report();
    end
    @(posedge mclk);
    channelEnable[1] <= 1'b0;
    cyc(4);
    note(2, 1, 16'h0008);
    @(posedge mclk);
    flagClear[9:5] <= 5'h17;
    @(posedge mclk);
    flagClear <= '0;
    cyc(2);
    note(2, 1, 16'h0008);
    @(posedge mclk);
    flagClear[9:5] <= 5'h08;
    @(posedge mclk);
    flagClear <= '0;
    cyc(2);
    note(2, 1, 16'h0000);
    // Pin sources on channel 2
    inv = 1'($random(seed));
    n = 1 + ($random(seed) & 7);
    timerPin[0] <= inv;
    cfg(2, 4'h0, 2'h1, CM_ACTIVE, CAP_OFF, 1'b0, inv);
    channelEnable[2] <= 1'b1;
    snap(2, b);
    pulse(0, inv, n);
    note(0, 2, b + 16'(n));
    cfg(2, 4'h0, 2'h1, CM_BOTH, CAP_OFF, 1'b0, inv);
    snap(2, b);
    pulse(0, inv, n);
    note(0, 2, b + 16'(2 * n));
    timerPin <= 4'b0010;
    cfg(2, 4'h0, 2'h1, CM_GATED, CAP_OFF, 1'b0, 1'b0);
    snap(2, b);
    pulse(0, 1'b0, n);
    note(0, 2, b + 16'(n));
    timerPin[1] <= 1'b0;
    cyc(6);
    snap(2, b);
    pulse(0, 1'b0, n);
    note(0, 2, b);
    timerPin[1] <= 1'b1;
    cfg(2, 4'h0, 2'h1, CM_DIR, CAP_OFF, 1'b0, 1'b0);
    snap(2, b);
    pulse(0, 1'b0, n);
    note(0, 2, b - 16'(n));
    // Trigger start and stop on channel 3
    cfg(3, 4'h8, 2'h2, CM_TRIG, CAP_OFF, 1'b0, 1'b0);
    channelEnable[3] <= 1'b1;
    delta_check(3, 32, 16'h0000);
    pulse(2, 1'b0, 1);
    delta_check(3, 32, 16'h0020);
    pulse(2, 1'b0, 1);
    delta_check(3, 32, 16'h0000);
    // Reload variant: each trigger edge reloads, counter keeps running
    cfg(3, 4'h8, 2'h2, CM_TRIG, CAP_RISE_RL, 1'b0, 1'b0);
    pulse(2, 1'b0, 1);
    note(0, 3, 16'h100D);
    pulse(2, 1'b0, 1);
    note(0, 3, 16'h100D);
    // Capture on falling edge only
    cfg(0, 4'h8, 2'h3, CM_ACTIVE, CAP_FALL, 1'b0, 1'b0);
    channelEnable[0] <= 1'b1;
    timerPin[3] <= 1'b1;
    cyc(8);
    note(1, 0, 16'h0000);
    @(posedge mclk);
    note(2, 0, 16'h0000);
    snap(0, b);
    @(posedge mclk);
    timerPin[3] <= 1'b0;
    cyc(8);
    note(2, 0, 16'h0010);
    note(1, 0, b + 16'h0003);
    for (n = 0; n < 10 && notes.size() > 0; n++)
      @(posedge mclk);
    if (notes.size() > 0)
      error_cnt++;
    final_report();
  end
endmodule : test_four_channel_timer_count_engine
bind fctce_engine fctce_engine_properties #(.NCH(NCH)) u_props (.mclk(mclk), .sys_rst(sys_rst),
  .channelEnable(channelEnable), .debugMode(debugMode), .primarySel(primarySel), .countMode(countMode),
  .countDown(countDown), .debugAction(debugAction), .flagClear(flagClear), .flagIntEnable(flagIntEnable),
  .statusFlags(statusFlags), .flagIrq(flagIrq), .countValue(countValue), .captureValue(captureValue),
  .channel_output_signal(channel_output_signal));
